// ---- logic/arm_result_monitor.v ----
// converter result monitor: result counter, threshold comparator, accumulator, mode control
`timescale 1ns/100ps
`default_nettype none
`include "arm_map.vh"

module arm_result_monitor #(
   parameter [15:0] TEMP_GAIN_FACTORY = 16'h5555, // arbitrary default
   parameter [15:0] LP_REF_FACTORY = 16'h8000
) (
   // clock and reset
   input wire clk_sys_in,
   input wire reset_n_in,
   // wishbone slave
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_we_in,
   input wire [31:0] wb_adr_in,
   input wire [3:0] wb_sel_in,
   input wire [31:0] wb_dat_in,
   output reg [31:0] wb_dat_out,
   output reg wb_ack_out,
   // filtered current results
   input wire result_valid_in,
   input wire [15:0] result_data_in,
   // temperature gain calibration engine
   input wire tgain_cal_valid_in,
   input wire [15:0] tgain_cal_data_in,
   output reg tgain_cal_start_out,
   // converter control
   output reg conv_irq_out,
   output reg lp_clock_sel_out,
   output reg volt_chan_en_out,
   output reg [9:0] fixed_gain_out,
   output reg lp_ref_sel_out
);

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [15:0] temp_gain_cal_r;
   reg [15:0] result_count_limit_r;
   reg [15:0] result_count_value_r;
   reg [15:0] current_threshold_r;
   reg [7:0] threshold_count_limit_r;
   reg [7:0] threshold_count_value_r;
   reg [31:0] current_accumulator_r;
   reg [15:0] lowpower_ref_scale_r;
   reg [15:0] converter_config_r;
   reg [7:0] converter_mode_r;
   reg [15:0] current_channel_control_r;
   reg [15:0] offset_cal_coeff_r;
   reg [15:0] current_result_r;
   reg ready_flag_r;
   reg thresh_flag_r;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   wire wr = req & wb_we_in;
   wire rd = req & ~wb_we_in;
   wire [31:0] bmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                        {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
   wire wr_tgain = wr & (wb_adr_in == `ARM_TEMP_GAIN_CAL_ADR);
   wire wr_rcl = wr & (wb_adr_in == `ARM_RES_CNT_LIMIT_ADR);
   wire wr_th = wr & (wb_adr_in == `ARM_THRESHOLD_ADR);
   wire wr_tcl = wr & (wb_adr_in == `ARM_THR_CNT_LIMIT_ADR);
   wire wr_ref = wr & (wb_adr_in == `ARM_LP_REF_SCALE_ADR);
   wire wr_cfg = wr & (wb_adr_in == `ARM_CONFIG_ADR);
   wire wr_mode = wr & (wb_adr_in == `ARM_MODE_ADR);
   wire wr_sta = wr & (wb_adr_in == `ARM_STATUS_ADR);
   wire wr_ctrl = wr & (wb_adr_in == `ARM_CHAN_CTRL_ADR);
   wire wr_ofs = wr & (wb_adr_in == `ARM_OFFSET_CAL_ADR);
   wire rd_res = rd & (wb_adr_in == `ARM_RESULT_ADR);

   // merge byte lanes into a 16-bit register
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] dat;
      input [31:0] msk;
      begin
         merge16 = (old & ~msk[15:0]) | (dat[15:0] & msk[15:0]);
      end
   endfunction

   // a reconfiguration restarts result counting and accumulation
   wire reconfig = wr_ctrl | wr_mode;

   // ----------------------------------------
   // result path
   // ----------------------------------------
   wire unipolar = current_channel_control_r[`ARM_CTRL_UNIPOLAR];
   wire [1:0] cmp_mode = converter_config_r[`ARM_CFG_CMP_HI:`ARM_CFG_CMP_LO];
   wire [1:0] acc_mode = converter_config_r[`ARM_CFG_ACC_HI:`ARM_CFG_ACC_LO];
   wire cnt_en = converter_config_r[`ARM_CFG_CNT_EN];

   // offset removal saturates rather than wraps, so a large coefficient
   // cannot flip the sign of a near-full-scale result
   wire [16:0] ofs_diff = {1'b0, result_data_in} - {1'b0, offset_cal_coeff_r};
   wire [16:0] sdiff = {result_data_in[15], result_data_in}
                       - {offset_cal_coeff_r[15], offset_cal_coeff_r};
   reg [15:0] corr;
   always @* begin
      if (unipolar) begin
         corr = ofs_diff[16] ? 16'h0000 : ofs_diff[15:0];
      end else if (sdiff[16] != sdiff[15]) begin
         corr = sdiff[16] ? 16'h8000 : 16'h7fff;
      end else begin
         corr = sdiff[15:0];
      end
   end

   // magnitude: negative full scale clamps to the largest 15-bit value
   wire [15:0] neg = 16'h0000 - corr;
   reg [15:0] mag;
   always @* begin
      if (unipolar) begin
         mag = corr;
      end else if (corr == 16'h8000) begin
         mag = 16'h7fff;
      end else begin
         mag = corr[15] ? {1'b0, neg[14:0]} : {1'b0, corr[14:0]};
      end
   end

   // only 15 threshold bits take part in twos complement format
   wire [15:0] th_eff = unipolar ? current_threshold_r
                                 : {1'b0, current_threshold_r[14:0]};
   wire at_or_above = (mag >= th_eff);
   wire above = (mag > th_eff);

   // ----------------------------------------
   // result counter
   // ----------------------------------------
   wire [15:0] rcv_inc = result_count_value_r + 16'h0001;
   wire limit_hit = (rcv_inc == result_count_limit_r);
   // without counting every result is reported
   wire ready_event = result_valid_in & (~cnt_en | limit_hit);

   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         result_count_value_r <= `ARM_RES_CNT_VALUE_RST;
      end else if (reconfig) begin
         result_count_value_r <= `ARM_RES_CNT_VALUE_RST;
      end else if (result_valid_in) begin
         result_count_value_r <= limit_hit ? 16'h0000 : rcv_inc;
      end
   end

   // ----------------------------------------
   // threshold hit counter
   // ----------------------------------------
   wire cnt_mode = (cmp_mode == `ARM_CMP_CNT_DEC) | (cmp_mode == `ARM_CMP_CNT_CLR);
   reg [7:0] thv_nxt;
   always @* begin
      thv_nxt = threshold_count_value_r;
      if (at_or_above) begin
         if (threshold_count_value_r != 8'hff) begin
            thv_nxt = threshold_count_value_r + 8'h01;
         end
      end else if (cmp_mode == `ARM_CMP_CNT_CLR) begin
         thv_nxt = 8'h00;
      end else if (threshold_count_value_r != 8'h00) begin
         thv_nxt = threshold_count_value_r - 8'h01;
      end
   end

   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         threshold_count_value_r <= `ARM_THR_CNT_VALUE_RST;
      end else if (result_valid_in & cnt_mode) begin
         threshold_count_value_r <= thv_nxt;
      end
   end

   // status is raised the moment the count reaches its limit
   wire thresh_event = result_valid_in & (
      (cnt_mode & (thv_nxt == threshold_count_limit_r)) |
      ((cmp_mode == `ARM_CMP_PLAIN) & above));

   // ----------------------------------------
   // accumulator
   // ----------------------------------------
   wire [31:0] ext = unipolar ? {16'h0000, corr} : {{16{corr[15]}}, corr};
   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         current_accumulator_r <= `ARM_ACCUM_RST;
      end else if (reconfig | (acc_mode == `ARM_ACC_OFF)) begin
         current_accumulator_r <= `ARM_ACCUM_RST;
      end else if (result_valid_in & (acc_mode == `ARM_ACC_ADD)) begin
         current_accumulator_r <= current_accumulator_r + ext;
      end else if (result_valid_in & (acc_mode == `ARM_ACC_SUB)) begin
         current_accumulator_r <= current_accumulator_r - ext;
      end
   end

   // ----------------------------------------
   // status flags and latest result
   // ----------------------------------------
   // a new event in the cycle of its clear still sets the flag
   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         ready_flag_r <= 1'b0;
         thresh_flag_r <= 1'b0;
         current_result_r <= 16'h0000;
      end else begin
         if (ready_event) begin
            ready_flag_r <= 1'b1;
         end else if (rd_res | (wr_sta & wb_dat_in[`ARM_STA_READY] & wb_sel_in[0])) begin
            ready_flag_r <= 1'b0;
         end
         if (thresh_event) begin
            thresh_flag_r <= 1'b1;
         end else if (wr_sta & wb_dat_in[`ARM_STA_THRESH] & wb_sel_in[0]) begin
            thresh_flag_r <= 1'b0;
         end
         // only a ready result that arrives while the ready flag is clear is kept
         if (ready_event & ~ready_flag_r) begin
            current_result_r <= corr;
         end
      end
   end

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         temp_gain_cal_r <= TEMP_GAIN_FACTORY;
         result_count_limit_r <= `ARM_RES_CNT_LIMIT_RST;
         current_threshold_r <= `ARM_THRESHOLD_RST;
         threshold_count_limit_r <= `ARM_THR_CNT_LIMIT_RST;
         lowpower_ref_scale_r <= LP_REF_FACTORY;
         converter_config_r <= `ARM_CONFIG_RST;
         converter_mode_r <= `ARM_MODE_RST;
         current_channel_control_r <= `ARM_CHAN_CTRL_RST;
         offset_cal_coeff_r <= `ARM_OFFSET_CAL_RST;
      end else begin
         // calibration result overrides a software write in the same cycle
         if (tgain_cal_valid_in) begin
            temp_gain_cal_r <= tgain_cal_data_in;
         end else if (wr_tgain) begin
            temp_gain_cal_r <= merge16(temp_gain_cal_r, wb_dat_in, bmask);
         end
         if (wr_rcl) begin
            result_count_limit_r <= merge16(result_count_limit_r, wb_dat_in, bmask);
         end
         if (wr_th) begin
            current_threshold_r <= merge16(current_threshold_r, wb_dat_in, bmask);
         end
         if (wr_tcl & wb_sel_in[0]) begin
            threshold_count_limit_r <= wb_dat_in[7:0];
         end
         if (wr_ref) begin
            lowpower_ref_scale_r <= merge16(lowpower_ref_scale_r, wb_dat_in, bmask);
         end
         if (wr_cfg) begin
            converter_config_r <= merge16(converter_config_r, wb_dat_in, bmask);
         end
         if (wr_mode & wb_sel_in[0]) begin
            converter_mode_r <= wb_dat_in[7:0];
         end
         if (wr_ctrl) begin
            current_channel_control_r <= merge16(current_channel_control_r, wb_dat_in, bmask);
         end
         if (wr_ofs) begin
            offset_cal_coeff_r <= merge16(offset_cal_coeff_r, wb_dat_in, bmask);
         end
      end
   end

   // ----------------------------------------
   // power mode outputs
   // ----------------------------------------
   // the core's own sleep state has no path into this logic
   wire [1:0] pwr = converter_mode_r[`ARM_MODE_PWR_HI:`ARM_MODE_PWR_LO];
   wire low_any = (pwr == `ARM_PWR_LOW) | (pwr == `ARM_PWR_LOW_PLUS);
   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         lp_clock_sel_out <= 1'b0;
         volt_chan_en_out <= 1'b1;
         fixed_gain_out <= 10'h000;
         lp_ref_sel_out <= 1'b0;
         tgain_cal_start_out <= 1'b0;
         conv_irq_out <= 1'b0;
      end else begin
         lp_clock_sel_out <= low_any;
         volt_chan_en_out <= ~low_any;
         if (pwr == `ARM_PWR_LOW) begin
            fixed_gain_out <= `ARM_GAIN_LOW;
         end else if (pwr == `ARM_PWR_LOW_PLUS) begin
            fixed_gain_out <= `ARM_GAIN_LOW_PLUS;
         end else begin
            fixed_gain_out <= 10'h000;
         end
         // reference choice only matters in the low modes
         lp_ref_sel_out <= low_any & ~converter_mode_r[`ARM_MODE_REF_SEL];
         tgain_cal_start_out <= wr_mode & wb_sel_in[0]
            & (wb_dat_in[`ARM_MODE_OP_HI:0] == `ARM_OP_TGAIN_CAL);
         // the flags keep working whatever the power mode
         conv_irq_out <= ready_flag_r | thresh_flag_r;
      end
   end

   // ----------------------------------------
   // read mux and acknowledge
   // ----------------------------------------
   reg [31:0] rd_mux;
   always @* begin
      case (wb_adr_in)
         `ARM_TEMP_GAIN_CAL_ADR: rd_mux = {16'h0000, temp_gain_cal_r};
         `ARM_RES_CNT_LIMIT_ADR: rd_mux = {16'h0000, result_count_limit_r};
         `ARM_RES_CNT_VALUE_ADR: rd_mux = {16'h0000, result_count_value_r};
         `ARM_THRESHOLD_ADR: rd_mux = {16'h0000, current_threshold_r};
         `ARM_THR_CNT_LIMIT_ADR: rd_mux = {24'h000000, threshold_count_limit_r};
         `ARM_THR_CNT_VALUE_ADR: rd_mux = {24'h000000, threshold_count_value_r};
         `ARM_ACCUM_ADR: rd_mux = current_accumulator_r;
         `ARM_LP_REF_SCALE_ADR: rd_mux = {16'h0000, lowpower_ref_scale_r};
         `ARM_CONFIG_ADR: rd_mux = {16'h0000, converter_config_r};
         `ARM_MODE_ADR: rd_mux = {24'h000000, converter_mode_r};
         `ARM_STATUS_ADR: rd_mux = {28'h0000000, thresh_flag_r, 2'h0, ready_flag_r};
         `ARM_CHAN_CTRL_ADR: rd_mux = {16'h0000, current_channel_control_r};
         `ARM_OFFSET_CAL_ADR: rd_mux = {16'h0000, offset_cal_coeff_r};
         `ARM_RESULT_ADR: rd_mux = {16'h0000, current_result_r};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // one wait state; unmapped addresses answer with zero
   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h00000000;
      end else begin
         wb_ack_out <= req;
         if (rd) begin
            wb_dat_out <= rd_mux;
         end
      end
   end

endmodule
`default_nettype wire

// ---- logic/arm_map.vh ----
// register map, field positions and reset values of the converter result monitor
`ifndef ARM_MAP_VH
`define ARM_MAP_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ARM_TEMP_GAIN_CAL_ADR 32'hffff0544
`define ARM_RES_CNT_LIMIT_ADR 32'hffff0548
`define ARM_RES_CNT_VALUE_ADR 32'hffff054c
`define ARM_THRESHOLD_ADR 32'hffff0550
`define ARM_THR_CNT_LIMIT_ADR 32'hffff0554
`define ARM_THR_CNT_VALUE_ADR 32'hffff0558
`define ARM_ACCUM_ADR 32'hffff055c
`define ARM_LP_REF_SCALE_ADR 32'hffff057c
`define ARM_CONFIG_ADR 32'hffff0580
`define ARM_MODE_ADR 32'hffff0584
`define ARM_STATUS_ADR 32'hffff0588
`define ARM_CHAN_CTRL_ADR 32'hffff058c
`define ARM_OFFSET_CAL_ADR 32'hffff0590
`define ARM_RESULT_ADR 32'hffff0594

// ----------------------------------------
// reset values
// ----------------------------------------
`define ARM_RES_CNT_LIMIT_RST 16'h0001
`define ARM_RES_CNT_VALUE_RST 16'h0000
`define ARM_THRESHOLD_RST 16'h0000
`define ARM_THR_CNT_LIMIT_RST 8'h01
`define ARM_THR_CNT_VALUE_RST 8'h00
`define ARM_ACCUM_RST 32'h00000000
`define ARM_CONFIG_RST 16'h0000
`define ARM_MODE_RST 8'h00
`define ARM_CHAN_CTRL_RST 16'h0000
`define ARM_OFFSET_CAL_RST 16'h0000

// ----------------------------------------
// field positions
// ----------------------------------------
`define ARM_CFG_CNT_EN 0
`define ARM_CFG_CMP_LO 3
`define ARM_CFG_CMP_HI 4
`define ARM_CFG_ACC_LO 5
`define ARM_CFG_ACC_HI 6
`define ARM_MODE_OP_HI 2
`define ARM_MODE_PWR_LO 3
`define ARM_MODE_PWR_HI 4
`define ARM_MODE_REF_SEL 5
`define ARM_CTRL_UNIPOLAR 0
`define ARM_STA_READY 0
`define ARM_STA_THRESH 3

// ----------------------------------------
// field codes
// ----------------------------------------
`define ARM_CMP_OFF 2'h0
`define ARM_CMP_PLAIN 2'h1
`define ARM_CMP_CNT_DEC 2'h2
`define ARM_CMP_CNT_CLR 2'h3
`define ARM_ACC_OFF 2'h0
`define ARM_ACC_ADD 2'h1
`define ARM_ACC_SUB 2'h2
`define ARM_PWR_NORMAL 2'h0
`define ARM_PWR_LOW 2'h1
`define ARM_PWR_LOW_PLUS 2'h2
`define ARM_OP_TGAIN_CAL 3'h7
`define ARM_GAIN_LOW 10'h080
`define ARM_GAIN_LOW_PLUS 10'h200

`endif

// ---- test/arm_result_monitor_checker.sv ----
// port-level assertions for the converter result monitor
`timescale 1ns/100ps
`default_nettype none
`include "arm_map.vh"
module arm_result_monitor_checker (
   // clock, reset and bus
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [31:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   // results and calibration
   input wire logic result_valid_in,
   input wire logic [15:0] result_data_in,
   input wire logic tgain_cal_valid_in,
   input wire logic [15:0] tgain_cal_data_in,
   input wire logic tgain_cal_start_out,
   // converter control
   input wire logic conv_irq_out,
   input wire logic lp_clock_sel_out,
   input wire logic volt_chan_en_out,
   input wire logic [9:0] fixed_gain_out,
   input wire logic lp_ref_sel_out
);
   logic [9:0] gain_r;
   logic ref_r;
   wire mode_wr = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[0] &&
      wb_adr_in == `ARM_MODE_ADR;
   // decode kept from the taking edge, since the bus data is gone once ack is seen
   always @(posedge clk_sys_in) begin
      if (mode_wr) begin
         gain_r <= wb_dat_in[4:3] == 2'h1 ? 10'h080 : wb_dat_in[4:3] == 2'h2 ? 10'h200 : 10'h000;
         ref_r <= (wb_dat_in[4:3] == 2'h1 || wb_dat_in[4:3] == 2'h2) && !wb_dat_in[5];
      end
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   a_normal_gain_free: assert property (volt_chan_en_out |-> fixed_gain_out == 10'h000)
      else $error("fixed gain set in normal mode");
   a_low_gain_fixed: assert property (lp_clock_sel_out |->
      (fixed_gain_out == 10'h080 || fixed_gain_out == 10'h200)) else $error("low mode gain");
   a_one_clock_src: assert property (lp_clock_sel_out != volt_chan_en_out)
      else $error("clock source and voltage channel disagree");
   a_ref_low_only: assert property (lp_ref_sel_out |-> lp_clock_sel_out)
      else $error("low power reference outside low modes");
   a_mode_sets_gain: assert property (mode_wr |-> ##[1:2] fixed_gain_out == gain_r)
      else $error("gain does not follow mode write");
   a_mode_sets_ref: assert property (mode_wr |-> ##[1:2] lp_ref_sel_out == ref_r)
      else $error("reference select does not follow mode write");
   a_cal_start_go: assert property (mode_wr && wb_dat_in[2:0] == 3'h7 |->
      ##[1:2] tgain_cal_start_out) else $error("calibration not started");
   a_cal_start_pulse: assert property (tgain_cal_start_out |=> !tgain_cal_start_out)
      else $error("calibration start longer than one cycle");
   a_irq_from_result: assert property ($rose(conv_irq_out) |->
      $past(result_valid_in, 2)) else $error("interrupt without a result");
endmodule
bind arm_result_monitor arm_result_monitor_checker u_chk (.clk_sys_in(clk_sys_in),
   .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
   .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
   .wb_ack_out(wb_ack_out), .result_valid_in(result_valid_in), .result_data_in(result_data_in),
   .tgain_cal_valid_in(tgain_cal_valid_in), .tgain_cal_data_in(tgain_cal_data_in),
   .tgain_cal_start_out(tgain_cal_start_out), .conv_irq_out(conv_irq_out),
   .lp_clock_sel_out(lp_clock_sel_out), .volt_chan_en_out(volt_chan_en_out),
   .fixed_gain_out(fixed_gain_out), .lp_ref_sel_out(lp_ref_sel_out));
`default_nettype wire

// ---- test/arm_filter_model.sv ----
// decimation filter and calibration engine model facing the result monitor
`timescale 1ns/100ps
`default_nettype none
module arm_filter_model #(
   parameter int CAL_DLY = 6,
   parameter logic [15:0] CAL_VAL = 16'h3a5c
) (
   // requests from the bench; calibration start from the monitor
   input wire logic clk_in,
   input wire logic send_in,
   input wire logic [15:0] data_in,
   input wire logic cal_start_in,
   // toward the monitor
   output var logic res_valid_out,
   output var logic [15:0] res_data_out,
   output var logic cal_valid_out,
   output var logic [15:0] cal_data_out
);
   int cal_cnt = 0;
   initial begin
      res_valid_out = 1'b0;
      res_data_out = 16'h0000;
      cal_valid_out = 1'b0;
      cal_data_out = 16'h0000;
   end
   // one result per request; between results the data shows junk, so stale use shows up
   always @(posedge clk_in) begin
      res_valid_out <= send_in;
      res_data_out <= send_in ? data_in : ~res_data_out;
   end
   // calibration answers some cycles after start, data valid only in that cycle
   always @(posedge clk_in) begin
      cal_valid_out <= cal_cnt == 1;
      cal_data_out <= cal_cnt == 1 ? CAL_VAL : ~cal_data_out;
      if (cal_start_in) cal_cnt <= CAL_DLY;
      else if (cal_cnt != 0) cal_cnt <= cal_cnt - 1;
   end
endmodule
`default_nettype wire

// ---- test/arm_result_monitor_tb.sv ----
// self-checking bench for the converter result monitor
`timescale 1ns/100ps
`default_nettype none
`include "arm_map.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module arm_result_monitor_tb;
   localparam logic [15:0] CAL = 16'h3a5c;
   logic clk_sys_in = 0, reset_n_in = 0, cyc = 0, stb = 0, we = 0, send = 0, flag;
   logic [31:0] adr = 0, wdat = 0, rdat, acc;
   logic [15:0] sdat = 0, d;
   wire [31:0] wb_dat;
   wire ack, rv, cv, start, irq, lpc, ve, lpr;
   wire [15:0] rd, cd;
   wire [9:0] gain;
   int errors = 0, compares = 0, thv, i, k;
   // free-running system clock
   always #2.5 clk_sys_in = ~clk_sys_in;
   arm_result_monitor dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat),
      .wb_dat_out(wb_dat), .wb_ack_out(ack), .result_valid_in(rv), .result_data_in(rd),
      .tgain_cal_valid_in(cv), .tgain_cal_data_in(cd), .tgain_cal_start_out(start),
      .conv_irq_out(irq), .lp_clock_sel_out(lpc), .volt_chan_en_out(ve),
      .fixed_gain_out(gain), .lp_ref_sel_out(lpr));
   arm_filter_model #(.CAL_VAL(CAL)) fm (.clk_in(clk_sys_in), .send_in(send), .data_in(sdat),
      .cal_start_in(start), .res_valid_out(rv), .res_data_out(rd), .cal_valid_out(cv),
      .cal_data_out(cd));
   // classic single cycle; the wait is bounded so a dead slave cannot hang the run
   task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] dt);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= dt;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (ack !== 1'b1 && n < 40);
      rdat = wb_dat;
      `CHK("ack", 1'b1, ack)
      cyc <= 0;
      stb <= 0;
   endtask
   task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] e);
      wb(0, a, 0);
      `CHK(nm, e, rdat)
   endtask
   // one result through the filter model, then let counters and flags settle
   task automatic res(input logic [15:0] dt);
      @(posedge clk_sys_in);
      send <= 1;
      sdat <= dt;
      @(posedge clk_sys_in);
      send <= 0;
      repeat (3) @(posedge clk_sys_in);
   endtask
   function automatic logic [15:0] mag(input logic [15:0] v, input logic uni);
      logic [15:0] n;
      n = -v;
      // negative full scale has no 15-bit magnitude and clamps to the largest one
      return uni ? v : v == 16'h8000 ? 16'h7fff : {1'b0, v[15] ? n[14:0] : v[14:0]};
   endfunction
   // expected hit count and sticky flag for one result in a counting mode
   task automatic thr(input logic [1:0] md, input logic uni, input logic [15:0] th,
      input logic [15:0] v);
      if (mag(v, uni) >= (uni ? th : {1'b0, th[14:0]})) thv = thv == 255 ? 255 : thv + 1;
      else thv = md == 2'h2 ? (thv == 0 ? 0 : thv - 1) : 0;
      if (thv == 2) flag = 1;
      res(v);
      rc("thv", `ARM_THR_CNT_VALUE_ADR, thv);
      wb(0, `ARM_STATUS_ADR, 0);
      `CHK("thflag", flag, rdat[3])
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog well beyond the expected run length
   initial begin
      #400000;
      errors++;
      end_of_test;
   end
   initial begin
      void'($urandom(32'h66907ac1));
      repeat (16) @(posedge clk_sys_in);
      reset_n_in <= 1;
      rc("tgain", `ARM_TEMP_GAIN_CAL_ADR, 32'h5555);
      rc("rcl", `ARM_RES_CNT_LIMIT_ADR, 32'h1);
      wb(1, `ARM_RES_CNT_VALUE_ADR, 32'hffff);
      rc("rcv", `ARM_RES_CNT_VALUE_ADR, 32'h0);
      rc("th", `ARM_THRESHOLD_ADR, 32'h0);
      rc("tcl", `ARM_THR_CNT_LIMIT_ADR, 32'h1);
      rc("thv", `ARM_THR_CNT_VALUE_ADR, 32'h0);
      wb(1, `ARM_ACCUM_ADR, 32'h1234);
      rc("acc", `ARM_ACCUM_ADR, 32'h0);
      rc("ref", `ARM_LP_REF_SCALE_ADR, 32'h8000);
      rc("unmapped", 32'hffff0600, 32'h0);
      $display("test reset done");
      for (i = 0; i < 6; i++) begin
         wb(1, `ARM_MODE_ADR, {26'h0, i[0], i[2:1], 3'h0});
         repeat (2) @(posedge clk_sys_in);
         `CHK("gain", i[2:1] == 1 ? 10'h080 : i[2:1] == 2 ? 10'h200 : 10'h0, gain)
         `CHK("lpclk", i[2:1] != 0, lpc)
         `CHK("volt", i[2:1] == 0, ve)
         `CHK("lpref", i[2:1] != 0 && !i[0], lpr)
      end
      wb(1, `ARM_MODE_ADR, 32'h7);
      repeat (12) @(posedge clk_sys_in);
      rc("tgain", `ARM_TEMP_GAIN_CAL_ADR, CAL);
      repeat (4600) @(posedge clk_sys_in);
      wb(1, `ARM_TEMP_GAIN_CAL_ADR, 32'h1357);
      rc("tgain", `ARM_TEMP_GAIN_CAL_ADR, 32'h1357);
      $display("test modes done");
      wb(1, `ARM_CONFIG_ADR, 32'h1);
      wb(1, `ARM_RES_CNT_LIMIT_ADR, 32'h3);
      rc("rcl", `ARM_RES_CNT_LIMIT_ADR, 32'h3);
      wb(1, `ARM_STATUS_ADR, 32'h9);
      for (i = 1; i < 6; i++) begin
         res(16'($urandom));
         rc("rcv", `ARM_RES_CNT_VALUE_ADR, i % 3);
         `CHK("irq", i >= 3, irq)
      end
      wb(1, `ARM_CHAN_CTRL_ADR, 32'h0);
      rc("rcv", `ARM_RES_CNT_VALUE_ADR, 0);
      res(16'h0042);
      wb(1, `ARM_MODE_ADR, 32'h0);
      rc("rcv", `ARM_RES_CNT_VALUE_ADR, 0);
      $display("test counter done");
      wb(1, `ARM_CONFIG_ADR, 32'h20);
      // ready is still set from the counter test; clear it so the ready check means something
      wb(1, `ARM_STATUS_ADR, 32'h9);
      acc = 0;
      for (i = 0; i < 10; i++) begin
         if (i == 6) wb(1, `ARM_CONFIG_ADR, 32'h40);
         k = $urandom_range(4000) - 2000;
         res(16'(k));
         acc = i < 6 ? acc + k : acc - k;
      end
      wb(0, `ARM_STATUS_ADR, 0);
      `CHK("ready", 1'b1, rdat[0])
      rc("acc", `ARM_ACCUM_ADR, acc);
      wb(1, `ARM_CHAN_CTRL_ADR, 32'h0);
      rc("acc", `ARM_ACCUM_ADR, 0);
      res(16'hff00);
      // subtract mode is still selected, so minus 0x100 is taken away
      rc("acc", `ARM_ACCUM_ADR, 32'h00000100);
      wb(1, `ARM_CONFIG_ADR, 32'h0);
      rc("acc", `ARM_ACCUM_ADR, 0);
      $display("test accumulator done");
      wb(1, `ARM_MODE_ADR, 32'h08);
      wb(1, `ARM_THRESHOLD_ADR, 32'h8100);
      wb(1, `ARM_THR_CNT_LIMIT_ADR, 32'h2);
      wb(1, `ARM_STATUS_ADR, 32'h9);
      thv = 0;
      flag = 0;
      for (k = 0; k < 3; k++) begin
         wb(1, `ARM_CONFIG_ADR, k == 0 ? 32'h10 : 32'h18);
         if (k == 2) wb(1, `ARM_CHAN_CTRL_ADR, 32'h1);
         if (k == 1) thr(2'h3, 1'b0, 16'h8100, 16'h8000);
         thr(k == 0 ? 2'h2 : 2'h3, k == 2, 16'h8100, 16'hff00);
         for (i = 0; i < 12; i++) begin
            d = $urandom_range(16'h200);
            thr(k == 0 ? 2'h2 : 2'h3, k == 2, 16'h8100,
               k == 2 ? 16'h8000 + d : ($urandom & 1 ? -d : d));
         end
      end
      wb(1, `ARM_CHAN_CTRL_ADR, 32'h0);
      wb(1, `ARM_CONFIG_ADR, 32'h08);
      for (i = 0; i < 2; i++) begin
         wb(1, `ARM_STATUS_ADR, 32'h9);
         res(16'h0100 + 16'(i));
         wb(0, `ARM_STATUS_ADR, 0);
         `CHK("plain", i[0], rdat[3])
      end
      $display("test comparator done");
      end_of_test;
   end
endmodule
`default_nettype wire
